// >>> i2c_status_level_hold_regs.sv
// Status, FIFO level and data hold-time registers of the I2C controller
//
// Overview of operation
// RULE_01 - Status register read-only, no interrupts
// RULE_02 - Bit 6 shows slave machine not idle
// RULE_03 - Bit 5 shows master machine not idle
// RULE_04 - Bit 0 is slave OR master activity
// RULE_05 - Bit 4 set when receive FIFO full
// RULE_06 - Bit 3 set when receive FIFO nonempty
// RULE_07 - Bit 2 set when transmit FIFO empty
// RULE_08 - Bit 1 set while transmit FIFO has room
// RULE_09 - Disable forces bits 1,2 high, 3 low
// RULE_10 - Idle while disabled clears bits 5,6
// RULE_11 - Transmit count follows pushes and pops
// RULE_12 - Transmit count zeroed on disable or abort
// RULE_13 - Receive count follows writes and reads
// RULE_14 - Receive count zeroed on disable or abort
// RULE_15 - Low 16 bits set transmit hold
// RULE_16 - Bits 23:16 set receive hold
// RULE_17 - Hold register writable only when disabled
// RULE_18 - Hold in core cycles, minimum per role
// RULE_19 - Software keeps hold below clock-low minus two
// RULE_20 - Hold fields reset to 0x0001 and 0x00
// RULE_21 - Disable flushes both FIFOs
// RULE_22 - Reserved bits read zero, writes ignored
`default_nettype none
module i2c_status_level_hold_regs
  import i2c_status_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic master_fsm_busy,
  input wire logic slave_fsm_busy,
  input wire logic tx_push,
  input wire logic tx_pop,
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic transmit_abort_flag,
  input wire logic slave_bulk_abort,
  input wire logic master_role,
  output logic enabled_state,
  output logic [15:0] tx_hold_cycles,
  output logic [7:0] rx_hold_cycles,
  output logic tx_hold_active,
  output logic fifo_flush
);

  logic enable_reg, enable_next;
  logic [level_w-1:0] tx_occupancy_reg, tx_occupancy_next;
  logic [level_w-1:0] rx_occupancy_reg, rx_occupancy_next;
  logic [15:0] tx_hold_reg, tx_hold_next;
  logic [7:0] rx_hold_reg, rx_hold_next;
  logic abort_seen_reg;
  logic master_busy_reg, slave_busy_reg;

  // AXI write and read path state
  logic aw_held_reg, w_held_reg, bvalid_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] bresp_reg, rresp_reg;

  // Activity bits: status reflects the engine's own idle state
  wire logic master_busy = master_fsm_busy; // [RULE_03]
  wire logic slave_busy = slave_fsm_busy; // [RULE_02]
  wire logic bus_active = master_busy_reg | slave_busy_reg; // [RULE_04]

  // Disable empties both FIFOs; flags are derived from counts so they follow
  wire logic tx_clear = ~enable_reg | abort_seen_reg | slave_bulk_abort; // [RULE_12] [RULE_21]
  wire logic rx_clear = ~enable_reg | abort_seen_reg; // [RULE_14] [RULE_21]

  wire logic rx_fifo_full = (rx_occupancy_reg == fifo_depth_count); // [RULE_05]
  wire logic rx_fifo_nonempty = (rx_occupancy_reg != level_zero); // [RULE_06] [RULE_09]
  wire logic tx_fifo_empty = (tx_occupancy_reg == level_zero); // [RULE_07] [RULE_09]
  wire logic tx_fifo_has_room = (tx_occupancy_reg != fifo_depth_count); // [RULE_08] [RULE_09]

  wire logic [31:0] status_word = {25'h0, slave_busy_reg, master_busy_reg, rx_fifo_full,
    rx_fifo_nonempty, tx_fifo_empty, tx_fifo_has_room, bus_active}; // [RULE_22]

  // Write channel acceptance
  wire logic aw_take = s_axi_awvalid & s_axi_awready;
  wire logic w_take = s_axi_wvalid & s_axi_wready;
  wire logic aw_have = aw_held_reg | aw_take;
  wire logic w_have = w_held_reg | w_take;
  wire logic [7:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire logic [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  wire logic [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  wire logic wr_fire = aw_have & w_have & ~bvalid_reg;
  wire logic wr_enable = wr_fire & (wr_addr == controller_enable_off);
  // Hold register refuses writes while the controller runs
  wire logic wr_hold = wr_fire & (wr_addr == data_hold_time_off) & ~enable_reg; // [RULE_17]
  wire logic wr_known = (wr_addr == controller_enable_off) | (wr_addr == data_hold_time_off);
  // Status and levels are read-only: writes there return an error
  wire logic [1:0] wr_resp = wr_known ? resp_okay : resp_slverr; // [RULE_01]

  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Read channel
  wire logic ar_take = s_axi_arvalid & s_axi_arready;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  wire logic rd_known = (s_axi_araddr == transfer_status_off) |
    (s_axi_araddr == tx_fifo_level_off) | (s_axi_araddr == rx_fifo_level_off) |
    (s_axi_araddr == data_hold_time_off) | (s_axi_araddr == controller_enable_off);
  wire logic [31:0] rd_word =
    (s_axi_araddr == transfer_status_off) ? status_word : // [RULE_01]
    (s_axi_araddr == tx_fifo_level_off) ? {27'h0, tx_occupancy_reg} : // [RULE_22]
    (s_axi_araddr == rx_fifo_level_off) ? {27'h0, rx_occupancy_reg} :
    (s_axi_araddr == data_hold_time_off) ? {8'h00, rx_hold_reg, tx_hold_reg} :
    (s_axi_araddr == controller_enable_off) ? {31'h0, enable_reg} : 32'h00000000;

  // Byte-lane merge for the hold and enable registers; upper byte of the hold register is reserved
  always_comb begin
    tx_hold_next = tx_hold_reg;
    rx_hold_next = rx_hold_reg;
    enable_next = enable_reg;
    if (wr_hold) begin
      if (wr_strb[0]) tx_hold_next[7:0] = wr_data[7:0]; // [RULE_15]
      if (wr_strb[1]) tx_hold_next[15:8] = wr_data[15:8];
      if (wr_strb[2]) rx_hold_next = wr_data[rx_hold_msb:rx_hold_lsb]; // [RULE_16] [RULE_22]
    end
    if (wr_enable && wr_strb[0]) begin
      enable_next = wr_data[enable_bit];
    end
  end

  // Occupancy counters; a push and pop in the same cycle cancel
  always_comb begin
    tx_occupancy_next = tx_occupancy_reg;
    if (tx_clear) begin
      tx_occupancy_next = level_zero; // [RULE_12]
    end else if (tx_push && !tx_pop && tx_fifo_has_room) begin
      tx_occupancy_next = tx_occupancy_reg + level_one; // [RULE_11]
    end else if (tx_pop && !tx_push && !tx_fifo_empty) begin
      tx_occupancy_next = tx_occupancy_reg - level_one; // [RULE_11]
    end
    rx_occupancy_next = rx_occupancy_reg;
    if (rx_clear) begin
      rx_occupancy_next = level_zero; // [RULE_14]
    end else if (rx_push && !rx_pop && !rx_fifo_full) begin
      rx_occupancy_next = rx_occupancy_reg + level_one; // [RULE_13]
    end else if (rx_pop && !rx_push && rx_fifo_nonempty) begin
      rx_occupancy_next = rx_occupancy_reg - level_one; // [RULE_13]
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      enable_reg <= 1'b0;
      tx_hold_reg <= tx_hold_reset; // [RULE_20]
      rx_hold_reg <= rx_hold_reset; // [RULE_20]
      tx_occupancy_reg <= level_zero;
      rx_occupancy_reg <= level_zero;
      abort_seen_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      tx_hold_reg <= tx_hold_next;
      rx_hold_reg <= rx_hold_next;
      tx_occupancy_reg <= tx_occupancy_next;
      rx_occupancy_reg <= rx_occupancy_next;
      abort_seen_reg <= transmit_abort_flag;
    end
  end

  // Activity is registered; engines report idle themselves after disable
  always_ff @(posedge clock) begin
    if (!resetn) begin
      master_busy_reg <= 1'b0;
      slave_busy_reg <= 1'b0;
    end else begin
      master_busy_reg <= master_busy; // [RULE_03] [RULE_10]
      slave_busy_reg <= slave_busy; // [RULE_02] [RULE_10]
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= resp_okay;
    end else begin
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_resp;
      end else begin
        if (aw_take) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= resp_okay;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_known ? resp_okay : resp_slverr;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // The line engine uses the hold only above the role minimum
  assign tx_hold_active = master_role ? (tx_hold_reg > tx_hold_min_master) :
    (tx_hold_reg > tx_hold_min_slave); // [RULE_18]
  assign tx_hold_cycles = tx_hold_reg; // [RULE_15]
  assign rx_hold_cycles = rx_hold_reg; // [RULE_16]
  assign enabled_state = enable_reg;
  assign fifo_flush = ~enable_reg; // [RULE_21]

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  a_status_activity_or: assert property (
    status_word[st_activity_bit] == (status_word[st_master_bit] | status_word[st_slave_bit]))
    else $error("activity bit not OR of master and slave"); // [RULE_04]
  a_master_busy_follow: assert property (master_fsm_busy |=> status_word[st_master_bit])
    else $error("master activity bit missed busy engine"); // [RULE_03]
  a_slave_idle_clear: assert property (!slave_fsm_busy |=> !status_word[st_slave_bit])
    else $error("slave activity bit stuck while idle"); // [RULE_02] [RULE_10]
  a_disabled_flags: assert property (!enable_reg |=> status_word[st_tx_has_room_bit] &&
    status_word[st_tx_empty_bit] && !status_word[st_rx_nonempty_bit])
    else $error("disabled state flags wrong"); // [RULE_09]
  a_tx_count_up: assert property (enable_reg && !transmit_abort_flag && !abort_seen_reg &&
    !slave_bulk_abort && tx_push && !tx_pop && tx_occupancy_reg < fifo_depth_count
    |=> tx_occupancy_reg == $past(tx_occupancy_reg) + level_one)
    else $error("transmit count did not rise"); // [RULE_11]
  a_rx_abort_zero: assert property (transmit_abort_flag |-> ##2 rx_occupancy_reg == level_zero)
    else $error("receive count not cleared by abort"); // [RULE_14]
  a_tx_abort_zero: assert property (slave_bulk_abort |=> tx_occupancy_reg == level_zero)
    else $error("transmit count not cleared by bulk abort"); // [RULE_12]
  a_rx_full_flag: assert property ( // [RULE_05]
    rx_occupancy_reg == fifo_depth_count && enable_reg && !abort_seen_reg && rx_push && !rx_pop
    |=> status_word[st_rx_full_bit])
    else $error("receive full flag dropped on extra write");
  a_rx_full_clears: assert property ( // [RULE_05]
    status_word[st_rx_full_bit] && enable_reg && !abort_seen_reg && rx_pop && !rx_push
    |=> !status_word[st_rx_full_bit])
    else $error("receive full flag kept after a read");
  a_hold_locked: assert property (enable_reg |=> $stable(tx_hold_reg) && $stable(rx_hold_reg))
    else $error("hold register changed while enabled"); // [RULE_17]
  a_hold_min_role: assert property (tx_hold_reg == tx_hold_min_slave && !master_role
    |-> !tx_hold_active) else $error("slave hold at minimum used"); // [RULE_18]

  // Bus answers: each answer stands until taken, so software may read at any time
  a_bvalid_stands: assert property ( // [RULE_01]
    s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_stands: assert property ( // [RULE_01]
    s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  a_read_answer: assert property ( // [RULE_01]
    ar_take
    |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property ( // [RULE_01]
    wr_fire
    |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  a_status_write_err: assert property ( // [RULE_01]
    wr_fire && wr_addr == transfer_status_off
    |=> s_axi_bresp == resp_slverr)
    else $error("status write not refused");
  a_status_reserved: assert property ( // [RULE_22]
    ar_take && s_axi_araddr == transfer_status_off
    |=> s_axi_rdata[31:7] == 25'h0 && s_axi_rresp == resp_okay)
    else $error("status reserved bits not zero");
  a_tx_level_read: assert property ( // [RULE_11]
    ar_take && s_axi_araddr == tx_fifo_level_off
    |=> s_axi_rdata == {27'h0, $past(tx_occupancy_reg)})
    else $error("transmit level read wrong");

  // Counter steps; clears take priority so they are excluded here
  a_tx_count_down: assert property ( // [RULE_11]
    enable_reg && !abort_seen_reg && !slave_bulk_abort && tx_pop && !tx_push &&
    tx_occupancy_reg != level_zero |=> tx_occupancy_reg == $past(tx_occupancy_reg) - level_one)
    else $error("transmit count did not fall");
  a_rx_count_up: assert property ( // [RULE_13]
    enable_reg && !abort_seen_reg && rx_push && !rx_pop && rx_occupancy_reg != fifo_depth_count
    |=> rx_occupancy_reg == $past(rx_occupancy_reg) + level_one)
    else $error("receive count did not rise");
  a_rx_count_down: assert property ( // [RULE_13]
    enable_reg && !abort_seen_reg && rx_pop && !rx_push && rx_occupancy_reg != level_zero
    |=> rx_occupancy_reg == $past(rx_occupancy_reg) - level_one)
    else $error("receive count did not fall");
  a_tx_disable_zero: assert property ( // [RULE_12] [RULE_21]
    !enable_reg
    |=> tx_occupancy_reg == level_zero)
    else $error("transmit count kept while disabled");
  a_rx_disable_zero: assert property ( // [RULE_14] [RULE_21]
    !enable_reg
    |=> rx_occupancy_reg == level_zero)
    else $error("receive count kept while disabled");
  a_tx_abort_seen: assert property ( // [RULE_12]
    transmit_abort_flag
    |-> ##2 tx_occupancy_reg == level_zero)
    else $error("transmit count not cleared by abort");
  a_tx_count_bound: assert property ( // [RULE_08]
    1'b1
    |-> tx_occupancy_reg <= fifo_depth_count)
    else $error("transmit count above depth");
  a_rx_count_bound: assert property ( // [RULE_05]
    1'b1
    |-> rx_occupancy_reg <= fifo_depth_count)
    else $error("receive count above depth");

  // Activity bits follow the engines one cycle late
  a_slave_busy_follow: assert property ( // [RULE_02]
    slave_fsm_busy
    |=> status_word[st_slave_bit])
    else $error("slave activity bit missed busy engine");
  a_master_idle_clear: assert property ( // [RULE_03] [RULE_10]
    !master_fsm_busy
    |=> !status_word[st_master_bit])
    else $error("master activity bit stuck while idle");

  // Hold register contents
  a_hold_reset: assert property ( // [RULE_20]
    $rose(resetn)
    |-> tx_hold_reg == tx_hold_reset && rx_hold_reg == rx_hold_reset)
    else $error("hold fields not at reset values");
  a_hold_write_lands: assert property ( // [RULE_15]
    wr_hold && wr_strb[0] && wr_strb[1]
    |=> tx_hold_reg == $past(wr_data[tx_hold_msb:tx_hold_lsb]))
    else $error("transmit hold write lost");
  a_rx_hold_write: assert property ( // [RULE_16]
    wr_hold && wr_strb[2]
    |=> rx_hold_reg == $past(wr_data[rx_hold_msb:rx_hold_lsb]))
    else $error("receive hold write lost");
  a_master_hold_min: assert property ( // [RULE_18]
    master_role && tx_hold_reg == tx_hold_min_master
    |-> !tx_hold_active)
    else $error("master hold at minimum used");

  c_tx_fill: cover property (tx_occupancy_reg == fifo_depth_count);
  c_rx_fill: cover property (rx_occupancy_reg == fifo_depth_count);
  c_hold_write: cover property (wr_hold ##1 tx_hold_reg != tx_hold_reset);
  c_abort_clear: cover property (tx_occupancy_reg != level_zero ##1 transmit_abort_flag);
  c_disable_busy: cover property (!enable_reg && status_word[st_slave_bit]);

endmodule : i2c_status_level_hold_regs
`default_nettype wire

// >>> i2c_status_pkg.sv
// Register map, field layout and reset values for the status/level/hold block
`default_nettype none
package i2c_status_pkg;
  localparam logic [7:0] transfer_status_off = 8'h70;
  localparam logic [7:0] tx_fifo_level_off = 8'h74;
  localparam logic [7:0] rx_fifo_level_off = 8'h78;
  localparam logic [7:0] data_hold_time_off = 8'h7c;
  localparam logic [7:0] controller_enable_off = 8'h6c;
  localparam int fifo_depth = 16;
  localparam int level_w = 5;
  localparam logic [level_w-1:0] fifo_depth_count = 5'h10;
  localparam logic [level_w-1:0] level_zero = 5'h00;
  localparam logic [level_w-1:0] level_one = 5'h01;
  localparam int st_activity_bit = 0;
  localparam int st_tx_has_room_bit = 1;
  localparam int st_tx_empty_bit = 2;
  localparam int st_rx_nonempty_bit = 3;
  localparam int st_rx_full_bit = 4;
  localparam int st_master_bit = 5;
  localparam int st_slave_bit = 6;
  localparam int tx_hold_lsb = 0;
  localparam int tx_hold_msb = 15;
  localparam int rx_hold_lsb = 16;
  localparam int rx_hold_msb = 23;
  localparam int enable_bit = 0;
  localparam logic [15:0] tx_hold_reset = 16'h0001;
  localparam logic [7:0] rx_hold_reset = 8'h00;
  localparam logic [15:0] tx_hold_min_master = 16'h0001;
  localparam logic [15:0] tx_hold_min_slave = 16'h0007;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : i2c_status_pkg
`default_nettype wire

// >>> engine_model.sv
// Behavioural model of the bus engine that drives activity and receive strobes
`default_nettype none
module engine_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic enabled_state,
  input wire logic start,
  input wire logic stop,
  input wire logic role,
  input wire logic [4:0] n_words,
  output logic master_fsm_busy,
  output logic slave_fsm_busy,
  output logic rx_push
);
  timeunit 1ns;
  timeprecision 1ns;
  logic active_reg;
  logic phase_reg;
  logic [4:0] left_reg;
  assign master_fsm_busy = active_reg && role;
  assign slave_fsm_busy = active_reg && !role;
  // Every other cycle, so the receive side also sees a slow writer
  assign rx_push = active_reg && phase_reg && (left_reg != 5'h00);
  always_ff @(posedge clock) begin
    if (!resetn || !enabled_state || stop) begin
      active_reg <= 1'b0;
      phase_reg <= 1'b0;
      left_reg <= 5'h00;
    end else if (start) begin
      active_reg <= 1'b1;
      left_reg <= n_words;
    end else if (active_reg) begin
      phase_reg <= !phase_reg;
      if (rx_push) left_reg <= left_reg - 5'h01;
    end
  end
endmodule : engine_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the status, level and hold-time registers
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench
  import i2c_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic master_fsm_busy, slave_fsm_busy, tx_push, tx_pop, rx_push, rx_pop;
  logic transmit_abort_flag, slave_bulk_abort, master_role, enabled_state;
  logic tx_hold_active, fifo_flush, start, stop;
  logic [15:0] tx_hold_cycles;
  logic [7:0] rx_hold_cycles;
  logic [4:0] n_words, k;
  logic [31:0] hd;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  logic [33:0] want_r;
  logic [1:0] want_b;
  logic [15:0] hv [4] = '{16'h0001, 16'h0002, 16'h0007, 16'h0008};
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  i2c_status_level_hold_regs i_dut (.clock, .resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .master_fsm_busy, .slave_fsm_busy, .tx_push,
    .tx_pop, .rx_push, .rx_pop, .transmit_abort_flag, .slave_bulk_abort, .master_role,
    .enabled_state, .tx_hold_cycles, .rx_hold_cycles, .tx_hold_active, .fifo_flush);
  engine_model i_engine (.clock, .resetn, .enabled_state, .start, .stop, .role(master_role),
    .n_words, .master_fsm_busy, .slave_fsm_busy, .rx_push);
  initial begin
    clock = 1'b0;
    forever #50 clock = !clock;
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
    if (s_axi_rvalid && s_axi_rready) begin
      want_r = exp_r.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, want_r)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      want_b = exp_b.pop_front();
      `CHK(s_axi_bresp, want_b)
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    exp_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Each channel is released only at the edge that takes it
    while (!(ta && tw)) begin
      @(posedge clock);
      if (!ta && s_axi_awready) begin ta = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!tw && s_axi_wready) begin tw = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge clock); while (!s_axi_bvalid);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = resp_okay);
    exp_r.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    // Ready stays high, so the answer is taken at the edge it is seen
    do @(posedge clock); while (!s_axi_rvalid);
  endtask : rd
  task automatic strobe(input int n, input logic [2:0] w);
    repeat (n) begin
      {tx_push, tx_pop, rx_pop} <= w;
      @(posedge clock);
    end
    {tx_push, tx_pop, rx_pop} <= 3'h0;
    @(posedge clock);
  endtask : strobe
  task automatic engine(input logic [4:0] n, input int wait_cycles, input logic halt);
    n_words <= n;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (wait_cycles) @(posedge clock);
    stop <= halt;
    @(posedge clock);
    stop <= 1'b0;
  endtask : engine
  function automatic logic [31:0] st(input logic [4:0] t, r, input logic m, s);
    return {25'h0, s, m, r == fifo_depth_count, r != level_zero, t == level_zero,
      t != fifo_depth_count, m | s};
  endfunction : st
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {tx_push, tx_pop, rx_pop, transmit_abort_flag, slave_bulk_abort, start, stop} = 7'h00;
    master_role = 1'b1;
    n_words = 5'h00;
    resetn = 1'b0;
    hd = $urandom(40740);
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    rd(transfer_status_off, 32'h06);
    rd(tx_fifo_level_off, 32'h0);
    rd(rx_fifo_level_off, 32'h0);
    rd(data_hold_time_off, 32'h1);
    rd(8'h40, 32'h0, resp_slverr);
    wr(transfer_status_off, 32'hffffffff, resp_slverr);
    rd(transfer_status_off, 32'h06);
    foreach (hv[i]) begin
      hd = $urandom;
      hd[15:0] = hv[i];
      wr(data_hold_time_off, hd, resp_okay);
      rd(data_hold_time_off, hd & 32'h00ffffff);
      `CHK(rx_hold_cycles, hd[23:16])
      `CHK(tx_hold_cycles, hd[15:0])
      master_role <= 1'b1;
      @(posedge clock);
      @(negedge clock) `CHK(tx_hold_active, hd[15:0] > 16'h0001)
      master_role <= 1'b0;
      @(posedge clock);
      @(negedge clock) `CHK(tx_hold_active, hd[15:0] > 16'h0007)
    end
    wr(controller_enable_off, 32'h1, resp_okay);
    `CHK(fifo_flush, 1'b0)
    `CHK(enabled_state, 1'b1)
    wr(data_hold_time_off, 32'h0, resp_okay);
    rd(data_hold_time_off, hd & 32'h00ffffff);
    k = 5'(1 + $urandom % 15);
    strobe(k, 3'h4);
    rd(tx_fifo_level_off, 32'(k));
    rd(transfer_status_off, st(k, 0, 0, 0));
    strobe(20, 3'h4);
    rd(transfer_status_off, st(16, 0, 0, 0));
    strobe(1, 3'h2);
    strobe(1, 3'h6);
    rd(tx_fifo_level_off, 32'd15);
    master_role <= 1'b1;
    engine(5'd16, 40, 1'b0);
    rd(rx_fifo_level_off, 32'd16);
    rd(transfer_status_off, st(15, 16, 1, 0));
    stop <= 1'b1;
    @(posedge clock);
    stop <= 1'b0;
    master_role <= 1'b0;
    engine(5'd0, 3, 1'b0);
    rd(transfer_status_off, st(15, 16, 0, 1));
    stop <= 1'b1;
    strobe(1, 3'h1);
    stop <= 1'b0;
    rd(transfer_status_off, st(15, 15, 0, 0));
    transmit_abort_flag <= 1'b1;
    @(posedge clock);
    transmit_abort_flag <= 1'b0;
    repeat (3) @(posedge clock);
    rd(tx_fifo_level_off, 32'h0);
    rd(rx_fifo_level_off, 32'h0);
    strobe(5, 3'h4);
    slave_bulk_abort <= 1'b1;
    @(posedge clock);
    slave_bulk_abort <= 1'b0;
    rd(tx_fifo_level_off, 32'h0);
    strobe(4, 3'h4);
    engine(5'd2, 8, 1'b0);
    wr(controller_enable_off, 32'h0, resp_okay);
    repeat (3) @(posedge clock);
    rd(transfer_status_off, 32'h06);
    strobe(2, 3'h4);
    rd(tx_fifo_level_off, 32'h0);
    rd(rx_fifo_level_off, 32'h0);
    `CHK(fifo_flush, 1'b1)
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
